/* File: verilog/ppic_cfg.svh */
// Register offsets, field positions, reset values and codes of the port block
`ifndef PPIC_CFG_SVH
`define PPIC_CFG_SVH
`define PPIC_OFF_STAT 12'h000
`define PPIC_OFF_TYPE 12'h004
`define PPIC_OFF_DM0 12'h008
`define PPIC_OFF_DM1 12'h00C
`define PPIC_OFF_DM2 12'h010
`define PPIC_OFF_SLEW 12'h014
`define PPIC_OFF_IBD 12'h018
`define PPIC_OFF_PORTCFG 12'h01C
`define PPIC_OFF_SIOCFG 12'h020
`define PPIC_OFF_DATA 12'h024
`define PPIC_OFF_PIN 12'h028
`define PPIC_OFF_RSTCFG 12'h02C
`define PPIC_PORTCFG_LVTTL 0
`define PPIC_SIOCFG_REG_OUT0 0
`define PPIC_SIOCFG_REG_OUT1 1
`define PPIC_SIOCFG_THR_LSB 2
`define PPIC_SIOCFG_HYST 4
`define PPIC_RSTCFG_DEF 2'h0
`define PPIC_THR_HALF_VDDIO 2'h0
`define PPIC_THR_04_VDDIO 2'h1
`define PPIC_THR_HALF_VREF 2'h2
`define PPIC_THR_VREF 2'h3
`define PPIC_DM_ANALOG 3'h0
`define PPIC_DM_HIZ_DIG 3'h1
`define PPIC_DM_PULL_UP 3'h2
`define PPIC_DM_PULL_DOWN 3'h3
`define PPIC_DM_OD_LOW 3'h4
`define PPIC_DM_OD_HIGH 3'h5
`define PPIC_DM_STRONG 3'h6
`define PPIC_DM_PULL_BOTH 3'h7
`define PPIC_EDGE_NONE 2'h0
`define PPIC_EDGE_RISE 2'h1
`define PPIC_EDGE_FALL 2'h2
`define PPIC_EDGE_BOTH 2'h3
`define PPIC_RESP_OKAY 2'h0
`define PPIC_RESP_SLVERR 2'h2
`endif

/* File: verilog/ppic_pkg.sv */
// Types shared by the port block modules
package ppic_pkg;
  typedef logic [1:0] ppic_edge_t;
  typedef logic [2:0] ppic_dm_t;
  typedef logic [7:0] ppic_byte_t;
  typedef logic [1:0] ppic_resp_t;
endpackage : ppic_pkg

/* File: verilog/ppic_irq_if.sv */
// Carrier between the port block and its interrupt unit
`timescale 1ns/100ps
interface ppic_irq_if;
  logic [7:0] pin_sync;
  logic [15:0] edge_type;
  logic stat_clear;
  logic [7:0] status;
  logic irq;
  modport unit (input pin_sync, input edge_type, input stat_clear, output status, output irq);
  modport ctrl (output pin_sync, output edge_type, output stat_clear, input status, input irq);
endinterface : ppic_irq_if

/* File: verilog/ppic_sync.sv */
// Two-stage synchroniser for the pin inputs
`timescale 1ns/100ps
module ppic_sync #(
  parameter int WIDTH = 8
) (
  // System
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ppic_sync_state_t;
  ppic_sync_state_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
  assign sync_out = st_reg.s2;
endmodule : ppic_sync

/* File: verilog/ppic_irq_unit.sv */
// Port interrupt unit: per-pin edge detection and sticky status
`timescale 1ns/100ps
`include "ppic_cfg.svh"
module ppic_irq_unit (
  // System
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Control side
  ppic_irq_if.unit bus
);
  import ppic_pkg::*;
  typedef struct packed {
    logic primed;
    logic [7:0] prev;
    logic [7:0] status;
  } ppic_irq_state_t;
  ppic_irq_state_t st_reg, st_next;
  logic [7:0] hit;

  function automatic logic edge_hit(ppic_edge_t mode, logic prv, logic cur);
    logic rise;
    logic fall;
    rise = !prv && cur;
    fall = prv && !cur;
    unique case (mode)
      `PPIC_EDGE_NONE: edge_hit = 1'b0;
      `PPIC_EDGE_RISE: edge_hit = rise;
      `PPIC_EDGE_FALL: edge_hit = fall;
      `PPIC_EDGE_BOTH: edge_hit = rise || fall;
    endcase
  endfunction : edge_hit

  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < 8; i++) begin
      // Edges only; no level sensing here
      hit[i] = st_reg.primed && edge_hit(bus.edge_type[2*i +: 2], st_reg.prev[i], bus.pin_sync[i]);
    end
    st_next.prev = bus.pin_sync;
    st_next.primed = 1'b1;
    // Set beats the read-clear in the same cycle
    st_next.status = (bus.stat_clear ? 8'h00 : st_reg.status) | hit;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign bus.status = st_reg.status;
  assign bus.irq = |st_reg.status;
endmodule : ppic_irq_unit

/* File: verilog/ppic_port.sv */
// Eight-pin port: configuration registers, pin drive, interrupt unit, AXI4-Lite slave
//
// Behaviour
// - One interrupt unit per eight-pin port with its own request line.
// - Each pin detects rising, falling, both edges or nothing.
// - Matching event sets pin status bit and raises port request.
// - One status bit per pin identifies the interrupting pin.
// - Interrupt detection keeps running in all sleep modes.
// - Only edge detection; level interrupts are built elsewhere.
// - Per-pin slew bit selects fast or slow edge rate.
// - Port-wide input threshold: CMOS default or LVTTL.
// - Each pin input buffer can be disabled in any drive mode.
// - Each special pin selects supply high level or regulated level.
// - No resistive pulls on special pin in regulated output mode.
// - Pin pair shares reference with four threshold choices.
// - Hysteresis enable for special pin input buffer.
// - All pins held high-Z analog while reset is active.
// - Stored reset configuration loaded into port reset register at release.
// - Pin state held unchanged through low-power modes.
// - All pins take part in the board-level boundary scan chain.
// - Three-bit drive mode per pin with eight codes.
// - Slew selection applies only to strong and open drain modes.
`timescale 1ns/100ps
`include "ppic_cfg.svh"
module ppic_port (
  // System
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic sleep,
  // Stored reset configuration (bit0 pull-up, bit1 pull-down)
  input wire logic [1:0] nv_reset_cfg,
  // Pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pull_up,
  output logic [7:0] pin_pull_down,
  output logic [7:0] pin_slow_slew,
  output logic [7:0] pin_ibuf_en,
  output logic pin_lvttl,
  output logic [1:0] sio_reg_out,
  output logic [1:0] sio_threshold,
  output logic sio_hyst_en,
  // Boundary scan
  input wire logic scan_mode,
  input wire logic [7:0] scan_out,
  input wire logic [7:0] scan_oe,
  output logic [7:0] scan_capture,
  // Interrupt request
  output logic port_irq,
  // AXI4-Lite
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output ppic_pkg::ppic_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output ppic_pkg::ppic_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import ppic_pkg::*;

  typedef enum logic [2:0] {
    PPIC_ST_HOLD = 3'b001,
    PPIC_ST_LOAD = 3'b010,
    PPIC_ST_RUN = 3'b100
  } ppic_phase_t;

  typedef struct packed {
    ppic_phase_t phase;
    logic [15:0] edge_type;
    ppic_byte_t dm0, dm1, dm2;
    ppic_byte_t slew, ibuf_dis, data;
    logic lvttl;
    logic [4:0] sio_cfg;
    logic [1:0] rst_cfg;
    logic aw_held, w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid, rvalid;
    ppic_resp_t bresp, rresp;
    logic [31:0] rdata;
    ppic_byte_t out_r, oe_r, pu_r, pd_r, slow_r, ibuf_r, scan_r;
    logic lvttl_r;
    logic [1:0] sio_reg_r, sio_thr_r;
    logic hyst_r, irq_r;
  } ppic_port_state_t;

  ppic_port_state_t st_reg, st_next;
  logic [7:0] pin_sync;
  logic stat_read;
  ppic_irq_if irq_bus ();

  function automatic logic addr_known(logic [11:0] a);
    unique case (a)
      `PPIC_OFF_STAT, `PPIC_OFF_TYPE, `PPIC_OFF_DM0, `PPIC_OFF_DM1, `PPIC_OFF_DM2,
      `PPIC_OFF_SLEW, `PPIC_OFF_IBD, `PPIC_OFF_PORTCFG, `PPIC_OFF_SIOCFG,
      `PPIC_OFF_DATA, `PPIC_OFF_PIN, `PPIC_OFF_RSTCFG: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction : addr_known

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // Pin inputs pass two flops first
  ppic_sync #(.WIDTH(8)) u_sync (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // Unit runs from the system clock regardless of sleep
  ppic_irq_unit u_irq (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .bus(irq_bus.unit)
  );
  assign irq_bus.pin_sync = pin_sync;
  assign irq_bus.edge_type = st_reg.edge_type;
  // Clear at the edge that takes the read; a later clear would drop fresh events
  assign stat_read = s_axi_arvalid && !st_reg.rvalid && (s_axi_araddr == `PPIC_OFF_STAT);
  assign irq_bus.stat_clear = stat_read;

  always_comb begin
    logic [31:0] wv;
    logic [31:0] rv;
    logic [2:0] dm;
    logic regulated;
    wv = '0;
    rv = '0;
    dm = '0;
    regulated = 1'b0;
    st_next = st_reg;

    // Stored reset configuration loads once at release
    unique case (st_reg.phase)
      PPIC_ST_HOLD: st_next.phase = PPIC_ST_LOAD;
      PPIC_ST_LOAD: begin
        st_next.rst_cfg = nv_reset_cfg;
        st_next.phase = PPIC_ST_RUN;
      end
      PPIC_ST_RUN: st_next.phase = PPIC_ST_RUN;
      default: st_next.phase = PPIC_ST_HOLD;
    endcase

    // Write channel: address and data in either order
    if (s_axi_awvalid && !st_reg.aw_held) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_held) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = addr_known(st_reg.aw_addr) ? `PPIC_RESP_OKAY : `PPIC_RESP_SLVERR;
      unique case (st_reg.aw_addr)
        `PPIC_OFF_TYPE: begin
          wv = merge({16'h0000, st_reg.edge_type}, st_reg.w_data, st_reg.w_strb);
          st_next.edge_type = wv[15:0];
        end
        `PPIC_OFF_DM0: begin
          wv = merge({24'h000000, st_reg.dm0}, st_reg.w_data, st_reg.w_strb);
          st_next.dm0 = wv[7:0];
        end
        `PPIC_OFF_DM1: begin
          wv = merge({24'h000000, st_reg.dm1}, st_reg.w_data, st_reg.w_strb);
          st_next.dm1 = wv[7:0];
        end
        `PPIC_OFF_DM2: begin
          wv = merge({24'h000000, st_reg.dm2}, st_reg.w_data, st_reg.w_strb);
          st_next.dm2 = wv[7:0];
        end
        `PPIC_OFF_SLEW: begin
          wv = merge({24'h000000, st_reg.slew}, st_reg.w_data, st_reg.w_strb);
          st_next.slew = wv[7:0];
        end
        `PPIC_OFF_IBD: begin
          wv = merge({24'h000000, st_reg.ibuf_dis}, st_reg.w_data, st_reg.w_strb);
          st_next.ibuf_dis = wv[7:0];
        end
        `PPIC_OFF_PORTCFG: begin
          wv = merge({31'h0, st_reg.lvttl}, st_reg.w_data, st_reg.w_strb);
          st_next.lvttl = wv[`PPIC_PORTCFG_LVTTL];
        end
        `PPIC_OFF_SIOCFG: begin
          wv = merge({27'h0000000, st_reg.sio_cfg}, st_reg.w_data, st_reg.w_strb);
          st_next.sio_cfg = wv[4:0];
        end
        `PPIC_OFF_DATA: begin
          wv = merge({24'h000000, st_reg.data}, st_reg.w_data, st_reg.w_strb);
          st_next.data = wv[7:0];
        end
        `PPIC_OFF_RSTCFG: begin
          wv = merge({30'h0, st_reg.rst_cfg}, st_reg.w_data, st_reg.w_strb);
          st_next.rst_cfg = wv[1:0];
        end
        default: wv = '0;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Read channel; status read clears it
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = addr_known(s_axi_araddr) ? `PPIC_RESP_OKAY : `PPIC_RESP_SLVERR;
      unique case (s_axi_araddr)
        `PPIC_OFF_STAT: rv = {24'h000000, irq_bus.status};
        `PPIC_OFF_TYPE: rv = {16'h0000, st_reg.edge_type};
        `PPIC_OFF_DM0: rv = {24'h000000, st_reg.dm0};
        `PPIC_OFF_DM1: rv = {24'h000000, st_reg.dm1};
        `PPIC_OFF_DM2: rv = {24'h000000, st_reg.dm2};
        `PPIC_OFF_SLEW: rv = {24'h000000, st_reg.slew};
        `PPIC_OFF_IBD: rv = {24'h000000, st_reg.ibuf_dis};
        `PPIC_OFF_PORTCFG: rv = {31'h0, st_reg.lvttl};
        `PPIC_OFF_SIOCFG: rv = {27'h0000000, st_reg.sio_cfg};
        `PPIC_OFF_DATA: rv = {24'h000000, st_reg.data};
        `PPIC_OFF_PIN: rv = {24'h000000, pin_sync};
        `PPIC_OFF_RSTCFG: rv = {30'h0, st_reg.rst_cfg};
        default: rv = '0;
      endcase
      st_next.rdata = rv;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // Pin drive. Config held across sleep; only software or reset changes it
    for (int i = 0; i < 8; i++) begin
      dm = {st_reg.dm2[i], st_reg.dm1[i], st_reg.dm0[i]};
      regulated = st_reg.sio_cfg[i % 2] && (i < 2);
      st_next.out_r[i] = st_reg.data[i];
      st_next.pu_r[i] = 1'b0;
      st_next.pd_r[i] = 1'b0;
      st_next.oe_r[i] = 1'b0;
      unique case (dm)
        `PPIC_DM_ANALOG, `PPIC_DM_HIZ_DIG: st_next.oe_r[i] = 1'b0;
        `PPIC_DM_PULL_UP: begin
          st_next.oe_r[i] = !st_reg.data[i];
          st_next.pu_r[i] = st_reg.data[i] && !regulated;
        end
        `PPIC_DM_PULL_DOWN: begin
          st_next.oe_r[i] = st_reg.data[i];
          st_next.pd_r[i] = !st_reg.data[i] && !regulated;
        end
        `PPIC_DM_OD_LOW: st_next.oe_r[i] = !st_reg.data[i];
        `PPIC_DM_OD_HIGH: st_next.oe_r[i] = st_reg.data[i];
        `PPIC_DM_STRONG: st_next.oe_r[i] = 1'b1;
        `PPIC_DM_PULL_BOTH: begin
          st_next.pu_r[i] = st_reg.data[i] && !regulated;
          st_next.pd_r[i] = !st_reg.data[i] && !regulated;
        end
      endcase
      // Slew only matters for strong and open drain modes
      st_next.slow_r[i] = !st_reg.slew[i] && dm[2] && (dm != `PPIC_DM_PULL_BOTH);
      // Analog mode has no digital input
      st_next.ibuf_r[i] = !st_reg.ibuf_dis[i] && (dm != `PPIC_DM_ANALOG);
      // Reset-configured pulls apply while pin stays in analog default
      if (dm == `PPIC_DM_ANALOG) begin
        st_next.pu_r[i] = st_reg.rst_cfg[0] && !regulated;
        st_next.pd_r[i] = st_reg.rst_cfg[1] && !regulated;
      end
    end
    // Scan overrides functional drive
    if (scan_mode) begin
      st_next.out_r = scan_out;
      st_next.oe_r = scan_oe;
      st_next.pu_r = 8'h00;
      st_next.pd_r = 8'h00;
    end
    st_next.scan_r = pin_sync;
    st_next.lvttl_r = st_reg.lvttl;
    st_next.sio_reg_r = st_reg.sio_cfg[1:0];
    st_next.sio_thr_r = st_reg.sio_cfg[3:2];
    st_next.hyst_r = st_reg.sio_cfg[`PPIC_SIOCFG_HYST];
    st_next.irq_r = irq_bus.irq;
  end

  // Reset clears all drive: pins high-Z analog
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.phase <= PPIC_ST_HOLD;
      st_reg.rst_cfg <= `PPIC_RSTCFG_DEF;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign pin_out = st_reg.out_r;
  assign pin_oe = st_reg.oe_r;
  assign pin_pull_up = st_reg.pu_r;
  assign pin_pull_down = st_reg.pd_r;
  assign pin_slow_slew = st_reg.slow_r;
  assign pin_ibuf_en = st_reg.ibuf_r;
  assign pin_lvttl = st_reg.lvttl_r;
  assign sio_reg_out = st_reg.sio_reg_r;
  assign sio_threshold = st_reg.sio_thr_r;
  assign sio_hyst_en = st_reg.hyst_r;
  assign scan_capture = st_reg.scan_r;
  assign port_irq = st_reg.irq_r;
  assign s_axi_awready = !st_reg.aw_held;
  assign s_axi_wready = !st_reg.w_held;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
endmodule : ppic_port

/* File: tb/ppic_port_properties.sv */
// Checker for the port block top ports: reset, pins, interrupt and bus relations
`timescale 1ns/100ps
module ppic_port_properties (
  // System
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] nv_reset_cfg,
  // Pins
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pull_up,
  input wire logic [7:0] pin_pull_down,
  input wire logic [7:0] pin_slow_slew,
  input wire logic [1:0] sio_reg_out,
  input wire logic scan_mode,
  input wire logic [7:0] scan_oe,
  input wire logic port_irq,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_reset_quiet: assert property (
    $fell(rst) |-> pin_oe == 8'h00 && (pin_pull_up | pin_pull_down) == 8'h00)
    else $error("pin active at reset release");
  a_reset_load: assert property (
    $fell(rst) |-> ##3 pin_pull_up == {8{nv_reset_cfg[0]}} &&
      pin_pull_down == {8{nv_reset_cfg[1]}})
    else $error("stored reset pulls not applied");
  // Either depth allowed: sync plus status plus request register
  a_irq_from_edge: assert property (
    $rose(port_irq) |-> $past(pin_in, 4) != $past(pin_in, 5) ||
      $past(pin_in, 5) != $past(pin_in, 6))
    else $error("request without pin edge");
  a_irq_drop_read: assert property (
    $fell(port_irq) |-> $past(s_axi_rvalid))
    else $error("request dropped without read");
  a_slew_no_pull: assert property (
    (pin_slow_slew & (pin_pull_up | pin_pull_down)) == 8'h00)
    else $error("slow slew on resistive pin");
  a_reg_no_pull: assert property (
    (sio_reg_out & (pin_pull_up[1:0] | pin_pull_down[1:0])) == 2'h0)
    else $error("pull on regulated special pin");
  a_scan_drive: assert property (
    scan_mode && $past(scan_mode) |-> pin_oe == $past(scan_oe) &&
      (pin_pull_up | pin_pull_down) == 8'h00)
    else $error("scan does not own pins");
  a_write_answer: assert property (write_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (read_taken |=> s_axi_rvalid)
    else $error("read response late");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_no_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while read pending");
endmodule : ppic_port_properties

bind ppic_port ppic_port_properties u_props (.clock, .rst, .nv_reset_cfg, .pin_in, .pin_oe,
  .pin_pull_up, .pin_pull_down, .pin_slow_slew, .sio_reg_out, .scan_mode, .scan_oe,
  .port_irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

/* File: tb/ppic_pin_env.sv */
// Board around the pins: external drivers, resistive pulls and floating lines
`timescale 1ns/100ps
module ppic_pin_env (
  // System
  input wire logic clock,
  // Device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pull_up,
  input wire logic [7:0] pin_pull_down,
  // Board side
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_level
);
  logic [7:0] float_reg;
  initial float_reg = 8'h00;
  // Undriven lines wander so a stale level never passes for an input
  always @(posedge clock) float_reg <= ~float_reg;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_level[i] = pin_out[i];
      else if (ext_en[i]) pin_level[i] = ext_level[i];
      else if (pin_pull_up[i] && !pin_pull_down[i]) pin_level[i] = 1'b1;
      else if (pin_pull_down[i] && !pin_pull_up[i]) pin_level[i] = 1'b0;
      else pin_level[i] = float_reg[i];
    end
  end
endmodule : ppic_pin_env

/* File: tb/ppic_port_test.sv */
// Self-checking bench for the eight-pin port block
`timescale 1ns/100ps
`include "ppic_cfg.svh"
module ppic_port_test;
  import ppic_pkg::*;
  logic clock, rst, ce, sleep, scan_mode, pin_lvttl, sio_hyst_en, port_irq;
  logic [1:0] nv_reset_cfg, sio_reg_out, sio_threshold;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_slow_slew, pin_ibuf_en;
  logic [7:0] scan_out, scan_oe, scan_capture, ext_en, ext_level;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  ppic_resp_t s_axi_bresp, s_axi_rresp, rs;
  int err_count, total_checks, cycles;
  logic eo;

  ppic_port dut (.clock, .rst, .ce, .sleep, .nv_reset_cfg, .pin_in, .pin_out, .pin_oe,
    .pin_pull_up, .pin_pull_down, .pin_slow_slew, .pin_ibuf_en, .pin_lvttl, .sio_reg_out,
    .sio_threshold, .sio_hyst_en, .scan_mode, .scan_out, .scan_oe, .scan_capture, .port_irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ppic_pin_env board (.clock, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .ext_en,
    .ext_level, .pin_level(pin_in));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // Hold delays rready to make the slave keep its answer standing
  task automatic rd_reg(input logic [11:0] a, input int hold);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (hold == 0);
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && hold > 0) hold--;
      if (hold == 0 && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    {rst, ce, sleep, scan_mode, eo} = 5'b11000;
    {nv_reset_cfg, scan_out, scan_oe, ext_en, ext_level} = {2'h1, 32'h0};
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {24'h0, 32'h0, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {err_count, total_checks, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    tick(4);
    chk(pin_oe, 8'h00);
    chk({pin_pull_down, pin_pull_up}, 16'h00FF);
    rd_reg(`PPIC_OFF_RSTCFG, 2);
    chk(rd, 32'h1);
    for (int a = 4; a <= 'h24; a += 4) begin
      rd_reg(12'(a), 0);
      chk(rd, 32'h0);
      chk(32'(rs), 32'(`PPIC_RESP_OKAY));
    end
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      wr(`PPIC_OFF_DM0, m[0] ? 32'hFF : 32'h0);
      wr(`PPIC_OFF_DM1, m[1] ? 32'hFF : 32'h0);
      wr(`PPIC_OFF_DM2, m[2] ? 32'hFF : 32'h0);
      for (int d = 0; d < 2; d++) begin
        wr(`PPIC_OFF_DATA, d ? 32'hFF : 32'h0);
        tick(2);
        eo = m == 6 || (m == 2 && d == 0) || (m == 3 && d == 1) || (m == 4 && d == 0) ||
          (m == 5 && d == 1);
        chk(pin_oe, eo ? 8'hFF : 8'h00);
        chk(pin_out & pin_oe, eo && d == 1 ? 8'hFF : 8'h00);
        chk(pin_pull_up, m == 0 || ((m == 2 || m == 7) && d == 1) ? 8'hFF : 8'h00);
        chk(pin_pull_down, (m == 3 || m == 7) && d == 0 ? 8'hFF : 8'h00);
        chk(pin_slow_slew, m >= 4 && m <= 6 ? 8'hFF : 8'h00);
        chk(pin_ibuf_en, m == 0 ? 8'h00 : 8'hFF);
      end
    end
    wr(`PPIC_OFF_DM0, 32'h0);
    wr(`PPIC_OFF_SLEW, 32'h0F);
    wr(`PPIC_OFF_IBD, 32'h55);
    wr(`PPIC_OFF_PORTCFG, 32'h1);
    chk(32'(rs), 32'(`PPIC_RESP_OKAY));
    tick(2);
    chk({pin_slow_slew, pin_ibuf_en, 7'h0, pin_lvttl}, 24'hF0AA01);
    wr(`PPIC_OFF_IBD, 32'h0);
    wr(`PPIC_OFF_PORTCFG, 32'h0);
    tick(2);
    chk({pin_ibuf_en, 7'h0, pin_lvttl}, 16'hFF00);
    $display("test drive modes done");
    for (int t = 0; t < 4; t++) begin
      wr(`PPIC_OFF_SIOCFG, {27'h0, 1'b1, 2'(t), 2'(t)});
      tick(2);
      chk({sio_hyst_en, sio_threshold, sio_reg_out}, {1'b1, 2'(t), 2'(t)});
    end
    wr(`PPIC_OFF_SIOCFG, 32'h0);
    wr(`PPIC_OFF_DM2, 32'h0);
    wr(`PPIC_OFF_SIOCFG, 32'h1);
    tick(2);
    chk(pin_pull_up, 8'hFE);
    wr(`PPIC_OFF_DM1, 32'h0);
    tick(2);
    chk(pin_pull_up, 8'hFE);
    wr(`PPIC_OFF_SIOCFG, 32'h0);
    $display("test special pins done");
    wr(`PPIC_OFF_DM1, 32'h0);
    wr(`PPIC_OFF_DM0, 32'hFF);
    ext_en <= 8'hFF;
    wr(`PPIC_OFF_TYPE, 32'hE4E4);
    tick(6);
    rd_reg(`PPIC_OFF_STAT, 0);
    tick(3);
    chk(port_irq, 1'b0);
    ext_level <= 8'hFF;
    tick(6);
    chk(port_irq, 1'b1);
    rd_reg(`PPIC_OFF_STAT, 0);
    chk(rd, 32'hAA);
    tick(3);
    chk(port_irq, 1'b0);
    rd_reg(`PPIC_OFF_PIN, 0);
    chk(rd, 32'hFF);
    sleep <= 1'b1;
    ext_level <= 8'h00;
    tick(6);
    chk(port_irq, 1'b1);
    rd_reg(`PPIC_OFF_STAT, 0);
    chk(rd, 32'hCC);
    tick(8);
    chk(port_irq, 1'b0);
    sleep <= 1'b0;
    $display("test interrupts done");
    rd_reg(12'h030, 0);
    chk(rd, 32'h0);
    chk(32'(rs), 32'(`PPIC_RESP_SLVERR));
    wr(12'h030, 32'hFFFF);
    chk(32'(rs), 32'(`PPIC_RESP_SLVERR));
    $display("test unmapped done");
    scan_mode <= 1'b1;
    scan_oe <= 8'hF0;
    scan_out <= 8'h5A;
    ext_level <= 8'h3C;
    tick(5);
    chk({pin_oe, pin_out & pin_oe, pin_pull_up}, 24'hF05000);
    chk(scan_capture, 8'h5C);
    $display("test scan done");
    give_verdict();
  end
endmodule : ppic_port_test
